//--- rfef_defs.svh
// Offsets, field positions and reset values for the receive event flags
`ifndef RFEF_DEFS_SVH
`define RFEF_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RFEF_OFS_FLAGS     8'h00
`define RFEF_OFS_CTRL      8'h04
`define RFEF_OFS_THRESH    8'h08
`define RFEF_OFS_IRQ_STAT  8'h0C
`define RFEF_OFS_IRQ_MASK  8'h10
`define RFEF_OFS_LEVEL     8'h14

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define RFEF_BIT_SYNC      0
`define RFEF_BIT_PREAMBLE  1
`define RFEF_BIT_TIMEOUT   2
`define RFEF_BIT_LEVEL     3

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define RFEF_CTRL_ADDR_EN  0
`define RFEF_CTRL_CONT     1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RFEF_RST_FLAGS     4'h0
`define RFEF_RST_CTRL      2'h0
`define RFEF_RST_THRESH    8'hFF
`define RFEF_RST_MASK      4'h0

`endif

//--- rfef_pkg.sv
// Types shared by the receive event flag block
package rfef_pkg;

   // ----------------------------------------
   // Receive path events from the detectors
   // ----------------------------------------
   typedef struct packed {
      logic rx_mode;      // Receiver active, level
      logic timeout;      // Receive timeout, pulse
      logic preamble;     // Valid preamble seen, pulse
      logic sync;         // Sync word seen, pulse
      logic addr_match;   // Address matched, level
   } rfef_evt_type;

   // ----------------------------------------
   // Four flag bits, msb first
   // ----------------------------------------
   typedef struct packed {
      logic level;        // Signal strength over threshold
      logic timeout;      // Receive timeout
      logic preamble;     // Preamble found
      logic sync;         // Sync hit, with address when filtering on
   } rfef_flags_type;

   // ----------------------------------------
   // Bus slave phase
   // ----------------------------------------
   typedef enum logic [1:0] {
      RFEF_IDLE,
      RFEF_ACCESS,
      RFEF_DONE
   } rfef_phase_type;

endpackage

//--- rfef_top.sv
// Receive event flag register bank with APB slave and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "rfef_defs.svh"

// What this block does
// - In receive, level flag sets above threshold
// - Level flag clears leaving receive or write-one
// - Timeout flag sets; clears leaving receive, emptying
// - Preamble flag sets on valid preamble
// - Preamble flag clears on write-one
// - Sync flag sets on sync, plus address when filtering on
// - Sync flag clears leaving receive, FIFO emptied
// - Sync flag write-clear only in continuous mode
// - FIFO empty means zero bytes held
module rfef_top #(
   parameter int VAL_W  = 8,    // Signal strength width
   parameter int CNT_W  = 7     // FIFO byte count width
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire rfef_pkg::rfef_evt_type evt,
   input  wire logic [VAL_W-1:0]       signal_strength_value,
   input  wire logic [CNT_W-1:0]       fifo_count,
   output logic      [3:0]             flags_out,
   output logic                        irq
);

   // ----------------------------------------
   // State declarations
   // ----------------------------------------
   rfef_pkg::rfef_flags_type flags_ff;      // Flag bits
   rfef_pkg::rfef_flags_type nxt_flags;
   logic [1:0]               ctrl_ff;       // Filter and mode
   logic [1:0]               nxt_ctrl;
   logic [VAL_W-1:0]         thresh_ff;     // Strength threshold
   logic [VAL_W-1:0]         nxt_thresh;
   logic [3:0]               istat_ff;      // Sticky events
   logic [3:0]               nxt_istat;
   logic [3:0]               imask_ff;      // Interrupt enables
   logic [3:0]               nxt_imask;
   logic                     irq_ff;        // Interrupt level
   logic                     nxt_irq;
   logic                     rx_prev_ff;    // Last receive state
   logic                     empty_prev_ff; // Last FIFO empty
   logic                     nxt_rx_prev;
   logic                     nxt_empty_prev;
   rfef_pkg::rfef_phase_type phase_ff;      // Bus phase
   rfef_pkg::rfef_phase_type nxt_phase;
   logic [31:0]              rdata_ff;      // Read data
   logic [31:0]              nxt_rdata;
   logic                     slverr_ff;     // Bus error
   logic                     nxt_slverr;
   logic                     ready_ff;      // Bus ready
   logic                     nxt_ready;

   // ----------------------------------------
   // Decoded conditions
   // ----------------------------------------
   logic                     fifo_empty;    // No bytes held
   logic                     leave_rx;      // Receive just ended
   logic                     emptied;       // FIFO just drained
   logic                     wr_ok;         // Write completes now
   logic                     addr_hit;      // Mapped address
   logic [3:0]               set_evt;       // Flag set events
   logic [3:0]               w1c;           // Write-one bits

   // ----------------------------------------
   // Event decode
   // ----------------------------------------
   // Emptying counts on the edge, so a FIFO that stays empty does not
   // keep a fresh timeout from showing
   always_comb begin
      fifo_empty = (fifo_count == '0);
      leave_rx   = rx_prev_ff & ~evt.rx_mode;
      emptied    = fifo_empty & ~empty_prev_ff;
      set_evt    = 4'h0;
      // Strength compare only counts inside receive
      set_evt[`RFEF_BIT_LEVEL] = evt.rx_mode &
                                 (signal_strength_value > thresh_ff);
      set_evt[`RFEF_BIT_TIMEOUT]  = evt.timeout;
      set_evt[`RFEF_BIT_PREAMBLE] = evt.preamble;
      // Address gate applies only when filtering is on
      set_evt[`RFEF_BIT_SYNC] = evt.sync &
                                (~ctrl_ff[`RFEF_CTRL_ADDR_EN] |
                                 evt.addr_match);
   end

   // ----------------------------------------
   // Edge history
   // ----------------------------------------
   always_comb begin
      nxt_rx_prev    = evt.rx_mode;
      nxt_empty_prev = fifo_empty;
   end

   // Starts empty so the first cycle is no drain event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_prev_ff    <= 1'b0;
         empty_prev_ff <= 1'b1;
      end else begin
         rx_prev_ff    <= nxt_rx_prev;
         empty_prev_ff <= nxt_empty_prev;
      end
   end

   // ----------------------------------------
   // Bus phase tracking
   // ----------------------------------------
   // Ready is registered, so every transfer has one access cycle
   always_comb begin
      nxt_phase = phase_ff;
      nxt_ready = 1'b0;
      case (phase_ff)
         rfef_pkg::RFEF_IDLE: begin
            if (psel && !penable) begin
               nxt_phase = rfef_pkg::RFEF_ACCESS;
               nxt_ready = 1'b1;
            end
         end
         rfef_pkg::RFEF_ACCESS: begin
            nxt_phase = rfef_pkg::RFEF_IDLE;
         end
         default: begin
            nxt_phase = rfef_pkg::RFEF_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= rfef_pkg::RFEF_IDLE;
         ready_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         ready_ff <= nxt_ready;
      end
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   always_comb begin
      wr_ok    = psel & penable & ready_ff & pwrite;
      addr_hit = 1'b1;
      if (paddr == `RFEF_OFS_FLAGS) begin
         addr_hit = 1'b1;
      end else if (paddr == `RFEF_OFS_CTRL) begin
         addr_hit = 1'b1;
      end else if (paddr == `RFEF_OFS_THRESH) begin
         addr_hit = 1'b1;
      end else if (paddr == `RFEF_OFS_IRQ_STAT) begin
         addr_hit = 1'b1;
      end else if (paddr == `RFEF_OFS_IRQ_MASK) begin
         addr_hit = 1'b1;
      end else if (paddr == `RFEF_OFS_LEVEL) begin
         addr_hit = 1'b1;
      end else begin
         addr_hit = 1'b0;
      end
   end

   // ----------------------------------------
   // Flag bits
   // ----------------------------------------
   // Clears first, then sets, so a set in the clearing cycle wins
   always_comb begin
      w1c       = 4'h0;
      nxt_flags = flags_ff;
      if (wr_ok && (paddr == `RFEF_OFS_FLAGS)) begin
         // Zero bits leave flags alone; timeout bit has no write
         w1c[`RFEF_BIT_LEVEL]    = pwdata[`RFEF_BIT_LEVEL];
         w1c[`RFEF_BIT_PREAMBLE] = pwdata[`RFEF_BIT_PREAMBLE];
         // Sync bit is only writable in continuous mode
         w1c[`RFEF_BIT_SYNC] = pwdata[`RFEF_BIT_SYNC] &
                               ctrl_ff[`RFEF_CTRL_CONT];
      end
      // Level flag: leave receive or write one
      if (leave_rx || w1c[`RFEF_BIT_LEVEL]) begin
         nxt_flags.level = 1'b0;
      end
      // Timeout flag: leave receive or drain
      if (leave_rx || emptied) begin
         nxt_flags.timeout = 1'b0;
      end
      // Preamble flag: only software clears it
      if (w1c[`RFEF_BIT_PREAMBLE]) begin
         nxt_flags.preamble = 1'b0;
      end
      // Sync flag: leave receive, drain, or continuous write
      if (leave_rx || emptied || w1c[`RFEF_BIT_SYNC]) begin
         nxt_flags.sync = 1'b0;
      end
      // Sets take priority over every clear
      if (set_evt[`RFEF_BIT_LEVEL]) begin
         nxt_flags.level = 1'b1;
      end
      if (set_evt[`RFEF_BIT_TIMEOUT]) begin
         nxt_flags.timeout = 1'b1;
      end
      if (set_evt[`RFEF_BIT_PREAMBLE]) begin
         nxt_flags.preamble = 1'b1;
      end
      if (set_evt[`RFEF_BIT_SYNC]) begin
         nxt_flags.sync = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff <= `RFEF_RST_FLAGS;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Threshold resets high so nothing fires before it is set
   always_comb begin
      nxt_ctrl   = ctrl_ff;
      nxt_thresh = thresh_ff;
      nxt_imask  = imask_ff;
      if (wr_ok && (paddr == `RFEF_OFS_CTRL)) begin
         nxt_ctrl = pwdata[1:0];
      end
      if (wr_ok && (paddr == `RFEF_OFS_THRESH)) begin
         nxt_thresh = pwdata[VAL_W-1:0];
      end
      if (wr_ok && (paddr == `RFEF_OFS_IRQ_MASK)) begin
         nxt_imask = pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff   <= `RFEF_RST_CTRL;
         thresh_ff <= VAL_W'(`RFEF_RST_THRESH);
         imask_ff  <= `RFEF_RST_MASK;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         thresh_ff <= nxt_thresh;
         imask_ff  <= nxt_imask;
      end
   end

   // ----------------------------------------
   // Interrupt status and line
   // ----------------------------------------
   // Sticky copy of set events; write one clears, a set wins
   always_comb begin
      nxt_istat = istat_ff;
      if (wr_ok && (paddr == `RFEF_OFS_IRQ_STAT)) begin
         nxt_istat = istat_ff & ~pwdata[3:0];
      end
      nxt_istat = nxt_istat | set_evt;
      // Line follows the registered status, one cycle behind it
      nxt_irq   = |(istat_ff & imask_ff);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_ff <= 4'h0;
         irq_ff   <= 1'b0;
      end else begin
         istat_ff <= nxt_istat;
         irq_ff   <= nxt_irq;
      end
   end

   // ----------------------------------------
   // Read data path
   // ----------------------------------------
   // Captured in the setup cycle, held through the access cycle
   always_comb begin
      nxt_rdata  = rdata_ff;
      nxt_slverr = 1'b0;
      if (psel && !penable) begin
         nxt_rdata  = 32'h0000_0000;
         nxt_slverr = ~addr_hit;
         if (pwrite) begin
            nxt_rdata = 32'h0000_0000;
         end else if (paddr == `RFEF_OFS_FLAGS) begin
            nxt_rdata[3:0] = flags_ff;
         end else if (paddr == `RFEF_OFS_CTRL) begin
            nxt_rdata[1:0] = ctrl_ff;
         end else if (paddr == `RFEF_OFS_THRESH) begin
            nxt_rdata[VAL_W-1:0] = thresh_ff;
         end else if (paddr == `RFEF_OFS_IRQ_STAT) begin
            nxt_rdata[3:0] = istat_ff;
         end else if (paddr == `RFEF_OFS_IRQ_MASK) begin
            nxt_rdata[3:0] = imask_ff;
         end else if (paddr == `RFEF_OFS_LEVEL) begin
            nxt_rdata[VAL_W-1:0] = signal_strength_value;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff  <= 32'h0000_0000;
         slverr_ff <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         slverr_ff <= nxt_slverr;
      end
   end

   // ----------------------------------------
   // Outputs, all straight from flops
   // ----------------------------------------
   assign prdata    = rdata_ff;
   assign pready    = ready_ff;
   assign pslverr   = slverr_ff;
   assign flags_out = flags_ff;
   assign irq       = irq_ff;

endmodule
`default_nettype wire

//--- rfef_top_assertions.sv
// Port-level checks for the receive event flag block
`timescale 1ns/100ps
`default_nettype none
`include "rfef_defs.svh"
// ----------------------------------------
// Checker, sees only top-level ports
// ----------------------------------------
module rfef_top_assertions #(
   parameter int VAL_W = 8,   // Signal strength width
   parameter int CNT_W = 7    // FIFO byte count width
) (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [7:0]             paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire rfef_pkg::rfef_evt_type evt,
   input wire logic [VAL_W-1:0]       signal_strength_value,
   input wire logic [CNT_W-1:0]       fifo_count,
   input wire logic [3:0]             flags_out,
   input wire logic                   irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic wr_flags;   // Completed write to the flag word
   assign wr_flags = psel && penable && pready && pwrite && (paddr == `RFEF_OFS_FLAGS);

   // ----------------------------------------
   // Bus answer and flag behaviour
   // ----------------------------------------
   property p_ready;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no answer after setup");
   property p_err;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("error without answer");
   property p_rx_only;
      $rose(flags_out[3]) |-> $past(evt.rx_mode) || $past(evt.rx_mode, 2);
   endproperty
   a_rx_only: assert property (p_rx_only) else $error("level flag set outside receive");
   property p_lvl_clr;
      $fell(evt.rx_mode) |-> ##[1:2] !flags_out[3];
   endproperty
   a_lvl_clr: assert property (p_lvl_clr) else $error("level flag kept after receive");
   property p_tmo_set;
      evt.timeout |-> ##[1:2] flags_out[2];
   endproperty
   a_tmo_set: assert property (p_tmo_set) else $error("timeout flag not set");
   property p_pre_set;
      evt.preamble |-> ##[1:2] flags_out[1];
   endproperty
   a_pre_set: assert property (p_pre_set) else $error("preamble flag not set");
   property p_pre_w1c;
      wr_flags && pwdata[1] && !evt.preamble |-> ##[1:2] !flags_out[1];
   endproperty
   a_pre_w1c: assert property (p_pre_w1c) else $error("preamble flag not cleared");
   property p_sync_set;
      evt.sync && evt.addr_match |-> ##[1:2] flags_out[0];
   endproperty
   a_sync_set: assert property (p_sync_set) else $error("sync flag not set");
   property p_leave;
      $fell(evt.rx_mode) && !evt.sync && !evt.timeout |-> ##[1:2] !flags_out[2] && !flags_out[0];
   endproperty
   a_leave: assert property (p_leave) else $error("flags kept after receive");
   property p_empty;
      fifo_count == 0 && $past(fifo_count) != 0 && !evt.sync && !evt.timeout
         |-> ##[1:2] !flags_out[2] && !flags_out[0];
   endproperty
   a_empty: assert property (p_empty) else $error("flags kept after drain");

   // Continuous mode as last written over the bus
   logic cont_mode;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cont_mode <= 1'b0;
      end else if (psel && penable && pready && pwrite && (paddr == `RFEF_OFS_CTRL)) begin
         cont_mode <= pwdata[`RFEF_CTRL_CONT];
      end
   end
   property p_sync_ro;
      wr_flags && pwdata[0] && !cont_mode && flags_out[0] && evt.rx_mode && fifo_count != 0
         |=> flags_out[0];
   endproperty
   a_sync_ro: assert property (p_sync_ro) else $error("sync flag cleared in packet mode");
   property p_zero_wr;
      wr_flags && !pwdata[3] && flags_out[3] && evt.rx_mode |=> flags_out[3];
   endproperty
   a_zero_wr: assert property (p_zero_wr) else $error("zero write cleared level flag");

   // Main scenarios reached
   cover property (wr_flags);
   cover property (pslverr);
   cover property (irq);
endmodule
`default_nettype wire

//--- test_receive_event_flags.sv
// Directed testbench for the receive event flag block
`timescale 1ns/100ps
`default_nettype none
`include "rfef_defs.svh"
module test_receive_event_flags;
   logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]             paddr;                  // Bus address
   logic [31:0]            pwdata, prdata, rd;     // Bus data, last read
   logic                   err;                    // Last error answer
   rfef_pkg::rfef_evt_type evt;                    // Detector events
   logic [7:0]             signal_strength_value;  // Live strength
   logic [6:0]             fifo_count;             // Bytes held
   logic [3:0]             flags_out;              // Flag copy
   int                     failures, cmp_count;    // Tallies

   rfef_top #(.VAL_W(8), .CNT_W(7)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .evt(evt),
      .signal_strength_value(signal_strength_value), .fifo_count(fifo_count),
      .flags_out(flags_out), .irq(irq));

   // 200 MHz clock
   initial begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; waits an edge first so strobes never toggle twice per step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // Access phase held until ready; only the watchdog ends a hang
      @(posedge pclk);
      while (pready !== 1'h1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // Let inputs settle into the flags, then read and compare
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      repeat (2) @(posedge pclk);
      apb(1'h0, a, 32'h0);
      check(name, rd, exp);
   endtask

   // One-cycle event pulse on a field of the event word
   task automatic pulse(input int b);
      @(posedge pclk);
      evt[b] <= 1'h1;
      @(posedge pclk);
      evt[b] <= 1'h0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic final_report;
      $display("mismatches %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (5000) @(posedge pclk);
      failures++;
      final_report;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, evt} = '0;
      signal_strength_value = 8'h00;
      fifo_count = 7'h05;
      presetn = 1'h0;
      failures = 0;
      cmp_count = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      rd_chk("thresh", `RFEF_OFS_THRESH, 32'hFF);
      rd_chk("flags", `RFEF_OFS_FLAGS, 32'h0);
      rd_chk("unmapped", 8'h1C, 32'h0);
      check("slverr", {31'h0, err}, 32'h1);
      // Strength at and just over the threshold
      apb(1'h1, `RFEF_OFS_THRESH, 32'h40);
      evt.rx_mode <= 1'h1;
      signal_strength_value <= 8'h40;
      rd_chk("level eq", `RFEF_OFS_FLAGS, 32'h0);
      signal_strength_value <= 8'h41;
      rd_chk("level gt", `RFEF_OFS_FLAGS, 32'h8);
      signal_strength_value <= 8'h10;
      rd_chk("live level", `RFEF_OFS_LEVEL, 32'h10);
      apb(1'h1, `RFEF_OFS_FLAGS, 32'h0);
      rd_chk("zero write", `RFEF_OFS_FLAGS, 32'h8);
      apb(1'h1, `RFEF_OFS_FLAGS, 32'h8);
      rd_chk("level w1c", `RFEF_OFS_FLAGS, 32'h0);
      signal_strength_value <= 8'hFF;
      rd_chk("level again", `RFEF_OFS_FLAGS, 32'h8);
      evt.rx_mode <= 1'h0;
      rd_chk("level leave", `RFEF_OFS_FLAGS, 32'h0);
      // Timeout: read-only, cleared by drain to zero bytes or by leaving receive
      evt.rx_mode <= 1'h1;
      pulse(3);
      apb(1'h1, `RFEF_OFS_FLAGS, 32'h4);
      rd_chk("tmo ro", `RFEF_OFS_FLAGS, 32'hC);
      fifo_count <= 7'h01;
      rd_chk("tmo one byte", `RFEF_OFS_FLAGS, 32'hC);
      fifo_count <= 7'h00;
      rd_chk("tmo drain", `RFEF_OFS_FLAGS, 32'h8);
      fifo_count <= 7'h05;
      pulse(3);
      evt.rx_mode <= 1'h0;
      rd_chk("tmo leave", `RFEF_OFS_FLAGS, 32'h0);
      // Preamble survives drain, clears only by write-one
      pulse(2);
      fifo_count <= 7'h00;
      rd_chk("pre kept", `RFEF_OFS_FLAGS, 32'h2);
      apb(1'h1, `RFEF_OFS_FLAGS, 32'h2);
      rd_chk("pre w1c", `RFEF_OFS_FLAGS, 32'h0);
      fifo_count <= 7'h05;
      evt.rx_mode <= 1'h1;
      // Strength under threshold, so the level flag stays out of the sync checks
      signal_strength_value <= 8'h00;
      // Sync with address filtering, packet then continuous mode
      apb(1'h1, `RFEF_OFS_CTRL, 32'h1);
      pulse(1);
      rd_chk("sync no addr", `RFEF_OFS_FLAGS, 32'h0);
      evt.addr_match <= 1'h1;
      pulse(1);
      apb(1'h1, `RFEF_OFS_FLAGS, 32'h1);
      rd_chk("sync packet", `RFEF_OFS_FLAGS, 32'h1);
      apb(1'h1, `RFEF_OFS_CTRL, 32'h3);
      apb(1'h1, `RFEF_OFS_FLAGS, 32'h1);
      rd_chk("sync cont", `RFEF_OFS_FLAGS, 32'h0);
      // Filter off: sync alone sets the flag
      apb(1'h1, `RFEF_OFS_CTRL, 32'h2);
      evt.addr_match <= 1'h0;
      pulse(1);
      rd_chk("sync no filter", `RFEF_OFS_FLAGS, 32'h1);
      check("flags out set", {28'h0, flags_out}, 32'h1);
      pulse(1);
      fifo_count <= 7'h00;
      rd_chk("sync drain", `RFEF_OFS_FLAGS, 32'h0);
      fifo_count <= 7'h05;
      pulse(1);
      evt.rx_mode <= 1'h0;
      rd_chk("sync leave", `RFEF_OFS_FLAGS, 32'h0);
      check("flags out", {28'h0, flags_out}, 32'h0);
      // Interrupt: all four events seen, raise, mask and clear
      rd_chk("irq stat", `RFEF_OFS_IRQ_STAT, 32'hF);
      check("irq masked", {31'h0, irq}, 32'h0);
      apb(1'h1, `RFEF_OFS_IRQ_MASK, 32'h4);
      repeat (3) @(posedge pclk);
      check("irq high", {31'h0, irq}, 32'h1);
      apb(1'h1, `RFEF_OFS_IRQ_STAT, 32'h4);
      repeat (3) @(posedge pclk);
      check("irq clear", {31'h0, irq}, 32'h0);
      rd_chk("irq stat left", `RFEF_OFS_IRQ_STAT, 32'hB);
      final_report;
   end
endmodule

// Checker attached to every instance of the block
bind rfef_top rfef_top_assertions #(.VAL_W(VAL_W), .CNT_W(CNT_W)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
   .signal_strength_value(signal_strength_value), .fifo_count(fifo_count),
   .flags_out(flags_out), .irq(irq));
`default_nettype wire
